// ===== src/rmc_regs.vh
// command codes, frame sizes and field layout for the register move interpreter
//
// Operation
// RULE1 - absolute register moves take target position from named user data register
// RULE2 - relative register moves take distance from named user data register
// RULE3 - timed absolute register move is command 178 (0xB2), 9 words, thread 1
// RULE4 - velocity absolute register move is command 160 (0xA0), 9 words, thread 1
// RULE5 - timed relative register move is command 179 (0xB3), 9 words, thread 1
// RULE6 - velocity relative register move is command 161 (0xA1), 9 words, thread 1
// RULE7 - host gives accel time 0..65534 and total time 2..2147483647 ticks
// RULE8 - host gives accel 1..1073741823, velocity 0..2147483647, ratio under 7.86 s
// RULE9 - stop enable and stop state words follow the profile values
// RULE10 - accepted register move answered by bare acknowledge, no payload
`ifndef RMC_REGS_VH
`define RMC_REGS_VH
`define RMC_CMD_ABS_TIMED 8'hB2
`define RMC_CMD_ABS_VEL 8'hA0
`define RMC_CMD_REL_TIMED 8'hB3
`define RMC_CMD_REL_VEL 8'hA1
`define RMC_FRAME_WORDS 4'h9
`define RMC_THREAD 2'h1
`define RMC_ACC_TIME_MAX 32'h0000FFFE
`define RMC_TOTAL_TIME_MIN 32'h00000002
`define RMC_TOTAL_TIME_MAX 32'h7FFFFFFF
`define RMC_ACC_MIN 32'h00000001
`define RMC_ACC_MAX 32'h3FFFFFFF
`define RMC_VEL_MAX 32'h7FFFFFFF
`define RMC_RATIO_TICKS 32'h0000FFFE
`define RMC_ANS_ACK 2'h1
`define RMC_ANS_NAK 2'h2
`endif

// ===== src/rmc_check.v
// parameter range check for one register move frame
`timescale 1ns/1ps
`include "rmc_regs.vh"
module rmc_check (
  input wire timed_in,
  input wire [31:0] p1_in,
  input wire [31:0] p2_in,
  output wire ok_out
);
  wire timed_ok;
  wire vel_ok;
  wire [63:0] acc_scaled;
  // ratio check: velocity must be below accel times the ramp limit
  // both operands widened first so the product keeps all 64 bits on purpose
  assign acc_scaled = {32'h00000000, p1_in} * {32'h00000000, `RMC_RATIO_TICKS};
  assign timed_ok = (p1_in <= `RMC_ACC_TIME_MAX) && (p2_in >= `RMC_TOTAL_TIME_MIN) &&
                    (p2_in <= `RMC_TOTAL_TIME_MAX); // [RULE7]
  assign vel_ok = (p1_in >= `RMC_ACC_MIN) && (p1_in <= `RMC_ACC_MAX) &&
                  (p2_in <= `RMC_VEL_MAX) && ({32'h0, p2_in} < acc_scaled); // [RULE8]
  assign ok_out = timed_in ? timed_ok : vel_ok;
endmodule

// ===== src/rmc_top.v
// register sourced move command interpreter: frame capture, check, dispatch
`timescale 1ns/1ps
`include "rmc_regs.vh"
module rmc_top #(
  parameter REG_AW = 8
) (
  input wire clk_sys_in,
  input wire reset_in,
  input wire word_valid_in,
  input wire [15:0] word_in,
  input wire frame_start_in,
  output reg udr_rd_out,
  output reg [REG_AW-1:0] udr_addr_out,
  input wire udr_ack_in,
  input wire [31:0] udr_data_in,
  output reg move_valid_out,
  output reg move_rel_out,
  output reg move_timed_out,
  output reg [1:0] move_thread_out,
  output reg [31:0] move_target_out,
  output reg [31:0] move_p1_out,
  output reg [31:0] move_p2_out,
  output reg [15:0] move_stop_en_out,
  output reg [15:0] move_stop_st_out,
  output reg ans_valid_out,
  output reg [1:0] ans_code_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_COLLECT = 2'h1;
  localparam ST_FETCH = 2'h2;
  localparam ST_ANSWER = 2'h3;

  reg [1:0] state_q;
  reg [3:0] cnt_q;
  reg [15:0] words_q [0:8];
  reg ok_q;
  wire capture_w;
  wire restart_w;
  wire [3:0] slot_w;
  wire accept_w;
  wire [7:0] cmd_w;
  wire [31:0] p0_w;
  wire [31:0] p1_w;
  wire [31:0] p2_w;
  wire timed_w;
  wire rel_w;
  wire chk_ok;

  // recognised codes for this block
  function is_reg_move;
    input [7:0] c;
    begin
      is_reg_move = (c == `RMC_CMD_ABS_TIMED) || (c == `RMC_CMD_ABS_VEL) ||
                    (c == `RMC_CMD_REL_TIMED) || (c == `RMC_CMD_REL_VEL); // [RULE3] [RULE4] [RULE5] [RULE6]
    end
  endfunction

  // time based profile: accel time and total time instead of accel and velocity
  function is_timed;
    input [7:0] c;
    begin
      is_timed = (c == `RMC_CMD_ABS_TIMED) || (c == `RMC_CMD_REL_TIMED); // [RULE3] [RULE5]
    end
  endfunction

  // relative moves carry a distance, absolute moves a target position
  function is_rel;
    input [7:0] c;
    begin
      is_rel = (c == `RMC_CMD_REL_TIMED) || (c == `RMC_CMD_REL_VEL); // [RULE5] [RULE6]
    end
  endfunction

  // word 0 holds the command, then 32-bit params high word first
  assign cmd_w = words_q[0][7:0];
  assign p0_w = {words_q[1], words_q[2]};
  assign p1_w = {words_q[3], words_q[4]};
  assign p2_w = {words_q[5], words_q[6]};
  assign timed_w = is_timed(cmd_w);
  assign rel_w = is_rel(cmd_w);

  // a frame is only worth a register read when code and profile both pass
  assign accept_w = is_reg_move(cmd_w) && chk_ok;

  rmc_check u_check (
    .timed_in(timed_w),
    .p1_in(p1_w),
    .p2_in(p2_w),
    .ok_out(chk_ok)
  );

  // word slot for capture; a restart mid-collection always lands in word 0,
  // otherwise the new command would sit behind stale words of the dropped frame
  assign capture_w = word_valid_in && (state_q == ST_IDLE || state_q == ST_COLLECT);
  assign restart_w = (state_q == ST_COLLECT) && frame_start_in;
  assign slot_w = restart_w ? 4'h0 : cnt_q;

  // frame storage; sized to the nine-word frame
  integer i;
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      for (i = 0; i < 9; i = i + 1) begin
        words_q[i] <= 16'h0000;
      end
    end else if (capture_w && slot_w < `RMC_FRAME_WORDS) begin
      // words beyond the ninth are dropped; the frame length is fixed
      words_q[slot_w] <= word_in;
    end
  end

  // control sequence: collect, check, fetch register, answer
  always @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      ok_q <= 1'b0;
      udr_rd_out <= 1'b0;
      udr_addr_out <= {REG_AW{1'b0}};
      move_valid_out <= 1'b0;
      move_rel_out <= 1'b0;
      move_timed_out <= 1'b0;
      move_thread_out <= 2'h0;
      move_target_out <= 32'h00000000;
      move_p1_out <= 32'h00000000;
      move_p2_out <= 32'h00000000;
      move_stop_en_out <= 16'h0000;
      move_stop_st_out <= 16'h0000;
      ans_valid_out <= 1'b0;
      ans_code_out <= 2'h0;
    end else begin
      move_valid_out <= 1'b0;
      ans_valid_out <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (word_valid_in) begin
            cnt_q <= 4'h1;
            state_q <= ST_COLLECT;
          end
        end
        ST_COLLECT: begin
          if (frame_start_in) begin
            // a new frame mid-collection restarts capture
            cnt_q <= word_valid_in ? 4'h1 : 4'h0;
            state_q <= word_valid_in ? ST_COLLECT : ST_IDLE;
          end else if (cnt_q == `RMC_FRAME_WORDS) begin
            // decision cycle: the whole frame is stored and checked
            ok_q <= accept_w;
            if (accept_w) begin
              // register index from first parameter, low bits only
              udr_addr_out <= p0_w[REG_AW-1:0]; // [RULE1] [RULE2]
              udr_rd_out <= 1'b1;
              state_q <= ST_FETCH;
            end else begin
              state_q <= ST_ANSWER;
            end
          end else if (word_valid_in) begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        ST_FETCH: begin
          if (udr_ack_in) begin
            udr_rd_out <= 1'b0;
            // register value is absolute target or relative distance
            move_target_out <= udr_data_in; // [RULE1] [RULE2]
            move_rel_out <= rel_w;
            move_timed_out <= timed_w;
            move_thread_out <= `RMC_THREAD;
            move_p1_out <= p1_w;
            move_p2_out <= p2_w;
            move_stop_en_out <= words_q[7]; // [RULE9]
            move_stop_st_out <= words_q[8]; // [RULE9]
            move_valid_out <= 1'b1;
            state_q <= ST_ANSWER;
          end
        end
        ST_ANSWER: begin
          // ack carries no payload; bad params or foreign codes get nak
          ans_valid_out <= 1'b1;
          ans_code_out <= ok_q ? `RMC_ANS_ACK : `RMC_ANS_NAK; // [RULE10]
          cnt_q <= 4'h0;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== testbench/rmc_top_monitor.sv
// port assertions for rmc_top
`timescale 1ns/1ps
module rmc_top_monitor (
  input wire clk_sys_in, reset_in, udr_rd_out, udr_ack_in, move_valid_out, ans_valid_out,
  input wire [1:0] move_thread_out, ans_code_out,
  input wire [31:0] udr_data_in, move_target_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // fetch closes, then the move, then the acknowledge
  sequence got_s; udr_rd_out && udr_ack_in; endsequence
  sequence go_s; move_valid_out ##1 ans_valid_out && ans_code_out == 2'h1; endsequence
  fetch_to_ack_a:
    assert property (got_s |=> go_s) else $error("no move or ack");
  target_copy_a:
    assert property (got_s |=> move_target_out == $past(udr_data_in)) else $error("target");
  read_hold_a:
    assert property (udr_rd_out && !udr_ack_in |=> udr_rd_out) else $error("rd hold");
  read_drop_a:
    assert property (got_s |=> !udr_rd_out) else $error("rd drop");
  thread_one_a:
    assert property (move_valid_out |-> move_thread_out == 2'h1) else $error("thread");
  move_cause_a:
    assert property (move_valid_out |-> $past(udr_ack_in)) else $error("move cause");
  ack_cause_a:
    assert property (ans_valid_out && ans_code_out == 2'h1 |-> $past(move_valid_out))
      else $error("ack cause");
  ans_pulse_a:
    assert property (ans_valid_out |=> !ans_valid_out) else $error("ans pulse");
endmodule
bind rmc_top rmc_top_monitor mon (.*);

// ===== testbench/rmc_udr_model.sv
// user data register file model with a chosen answer delay
`timescale 1ns/1ps
module rmc_udr_model (
  input wire clk_sys_in, udr_rd_in,
  input wire [7:0] udr_addr_in,
  input wire [1:0] lag_in,
  output reg udr_ack_out = 1'b0,
  output reg [31:0] udr_data_out = 32'h5A5A5A5A
);
  reg [1:0] wait_q = 2'h0;
  // data toggles outside the ack cycle so a capture one cycle late cannot match
  always @(posedge clk_sys_in) begin
    udr_ack_out <= 1'b0;
    udr_data_out <= ~udr_data_out;
    if (udr_rd_in && !udr_ack_out) begin
      wait_q <= (wait_q == lag_in) ? 2'h0 : wait_q + 2'h1;
      if (wait_q == lag_in) begin
        udr_ack_out <= 1'b1;
        udr_data_out <= {udr_addr_in, 24'hC3A500};
      end
    end
  end
endmodule

// ===== testbench/rmc_top_test.sv
// self-checking bench for the register move interpreter
`timescale 1ns/1ps
module rmc_top_test;
  reg clk_sys_in = 0, reset_in = 1, word_valid_in = 0, frame_start_in = 0, mv;
  reg [15:0] word_in = 16'h0000;
  reg [1:0] lag = 2'h0;
  wire udr_rd_out, udr_ack_in, move_valid_out, move_rel_out, move_timed_out, ans_valid_out;
  wire [7:0] udr_addr_out;
  wire [1:0] move_thread_out, ans_code_out;
  wire [31:0] udr_data_in, move_target_out, move_p1_out, move_p2_out;
  wire [15:0] move_stop_en_out, move_stop_st_out;
  integer fail_count = 0, cmp_count = 0, i = 0;
  rmc_top dut (.*);
  rmc_udr_model udr (.clk_sys_in(clk_sys_in), .udr_rd_in(udr_rd_out),
    .udr_addr_in(udr_addr_out), .lag_in(lag), .udr_ack_out(udr_ack_in),
    .udr_data_out(udr_data_in));
  initial forever #25 clk_sys_in = ~clk_sys_in;
  task chk(input string n, input [134:0] seen, exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("unexpected %s: expected %h seen %h", n, exp, seen);
      end
    end
  endtask
  // nine words, high halves first; register index is i, answer awaited
  task frame(input [7:0] c, input [31:0] p1, p2);
    reg [143:0] f;
    integer k;
    begin
      f = {8'h00, c, 24'h000000, i[7:0], p1, p2, 32'h80010180};
      mv = 1'b0;
      for (k = 0; k < 9; k = k + 1) begin
        frame_start_in <= (k == 0);
        word_valid_in <= 1'b1;
        word_in <= f[143 - 16 * k -: 16];
        @(posedge clk_sys_in);
      end
      word_valid_in <= 1'b0;
      for (k = 0; k < 30 && ans_valid_out !== 1'b1; k = k + 1) begin
        @(posedge clk_sys_in);
        mv = mv | (move_valid_out === 1'b1);
      end
    end
  endtask
  // each code with boundary profile values and fetch delays 0..3
  task good_moves;
    reg [7:0] c;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        c = (i == 0) ? 8'hB2 : (i == 1) ? 8'hA0 : (i == 2) ? 8'hB3 : 8'hA1;
        lag <= i[1:0];
        frame(c, c[4] ? 32'h0000FFFE : 32'h1, c[4] ? 32'h2 : 32'h0000FFFD);
        // code bit 0 marks relative, bit 4 marks timed
        chk("move", {mv, ans_code_out, move_rel_out, move_timed_out, move_thread_out,
          move_target_out, move_p1_out, move_p2_out, move_stop_en_out, move_stop_st_out},
          {3'b101, c[0], c[4], 2'h1, i[7:0], 24'hC3A500, c[4] ? 32'h0000FFFE : 32'h1,
          c[4] ? 32'h2 : 32'h0000FFFD, 32'h80010180});
      end
    end
  endtask
  // a dropped partial frame, then a restart that must land in word 0
  task restart;
    integer k;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        frame_start_in <= (k == 0);
        word_valid_in <= 1'b1;
        word_in <= 16'h00B4;
        @(posedge clk_sys_in);
      end
      i = 5;
      frame(8'hB3, 32'h0000FFFE, 32'h2);
      chk("restart", {mv, ans_code_out, move_target_out}, {3'b101, 8'h05, 24'hC3A500});
    end
  endtask
  task nak(input [7:0] c, input [31:0] p1, p2);
    begin
      frame(c, p1, p2);
      chk("refusal", {mv, ans_code_out}, 3'b010);
    end
  endtask
  // unknown code and the accel time max, total time min, accel min and ratio limits just passed
  task bad_frames;
    begin
      nak(8'hB4, 32'h1, 32'h2);
      nak(8'hB2, 32'h0000FFFF, 32'h2);
      nak(8'hB3, 32'h1, 32'h1);
      nak(8'hA0, 32'h0, 32'h5);
      nak(8'hA1, 32'h1, 32'h0000FFFE);
    end
  endtask
  task give_verdict;
    begin
      if (fail_count == 0 && cmp_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(posedge clk_sys_in);
    good_moves;
    bad_frames;
    restart;
    give_verdict;
  end
  // backstop only: every answer wait gives up after 30 cycles, so the run ends long before this limit
  initial begin
    #100000;
    fail_count = fail_count + 1;
    give_verdict;
  end
endmodule
